// ==== design/mt_map.svh ====
// register offsets, field positions, reset values and timing of the terminal block
`ifndef MT_MAP_SVH
`define MT_MAP_SVH
`define MT_REG_FILT_A   8'h00
`define MT_REG_FILT_B   8'h04
`define MT_REG_POL      8'h08
`define MT_REG_OUT_FN   8'h0C
`define MT_REG_PULSE_FN 8'h20
`define MT_REG_ON_DLY   8'h24
`define MT_REG_OFF_DLY  8'h38
`define MT_REG_MON_LO   8'h4C
`define MT_REG_MON_HI   8'h58
`define MT_REG_STATUS   8'h64
`define MT_REG_FREQ     8'h68
`define MT_N_OUT        8'd5
`define MT_N_MON        8'd3
`define MT_STAT_OUT     16
`define MT_DIN_PULSE    8
`define MT_GRP_A_N      5
`define MT_FILT_RST     6'h05
`define MT_FILT_MIN     6'h01
`define MT_FILT_MAX     6'h32
`define MT_POL_RST      12'h000
`define MT_FN_RST       {7'h05, 7'h04, 7'h3F, 7'h02, 7'h01}
`define MT_FN_MAX       7'h47
`define MT_DLY_MAX      10'h3E8
`define MT_MON_HI_RST   16'hFFFF
`define MT_PULSE_LO     7'h61
`define MT_PULSE_HI     7'h62
`define MT_FREQ_MIN_LO  14'h0001
`define MT_FREQ_MAX_LO  14'h03E8
`define MT_FREQ_MIN_HI  14'h000A
`define MT_FREQ_MAX_HI  14'h2710
`define MT_EDGE_SAT     14'h3FFF
`define MT_CLK_HZ       125000000
`define MT_TICK_MS      1
`define MT_DLY_UNIT_MS  10
`define MT_GATE_MS      10
`define MT_PULSE_MS     500
`define MT_FN_READY     1
`define MT_FN_RUN       2
`define MT_FN_NORMAL    3
`define MT_FN_FAULT     4
`define MT_FN_ALARM     5
`define MT_FN_FLT_ALM   6
`define MT_FN_REVERSE   7
`define MT_FN_RUN_CMD   8
`define MT_FN_ZERO_RUN  9
`define MT_FN_NONZERO   10
`define MT_FN_UNDERV    11
`define MT_FN_REMOTE    12
`define MT_FN_REGEN     14
`define MT_FN_STAGE     19
`define MT_FN_CYC_P     20
`define MT_FN_CYC_L     21
`define MT_FN_CYC_P2    22
`define MT_FN_WOBBLE    23
`define MT_FN_ENC_DIR   24
`define MT_FN_MON_BASE  26
`define MT_FN_MON_STEP  3
`define MT_FN_DIN_BASE  55
`endif

// ==== design/mt_pkg.sv ====
// types shared by the terminal block
package mt_pkg;
	typedef enum logic [0:0] {
		MT_IDLE = 1'b0,
		MT_ACK  = 1'b1
	} mt_bus_type;

	typedef logic [2:0][15:0] mt_mon_type;

	typedef struct packed {
		mt_bus_type       bus;
		logic [31:0]      rdata;
		logic [5:0]       filt_a;
		logic [5:0]       filt_b;
		logic [11:0]      pol;
		logic [4:0][6:0]  fn;
		logic [6:0]       pfn;
		logic [4:0][9:0]  on_dly;
		logic [4:0][9:0]  off_dly;
		logic [2:0][15:0] mon_lo;
		logic [2:0][15:0] mon_hi;
		logic [16:0]      ms_cnt;
		logic [3:0]       tk10;
		logic [8:0][5:0]  db_cnt;
		logic [8:0]       din_f;
		logic [8:0]       din_act;
		logic [8:0]       stg_cnt;
		logic [8:0]       cyc_cnt;
		logic             cyc_lvl;
		logic [2:0]       mon_low;
		logic [2:0]       mon_high;
		logic [4:0][9:0]  dly_cnt;
		logic [4:0]       out;
		logic             pin_d;
		logic [3:0]       gate;
		logic [13:0]      edge_cnt;
		logic [13:0]      freq;
	} mt_state_type;
endpackage

// ==== design/mt_terminal_io.sv ====
// multifunction terminal block: input filter, pulse input, output routing
// How it works
// RULE1: code 97 measures pulses 0.10 to 100.00 kHz
// RULE2: code 98 measures pulses 1.0 to 1000.0 kHz
// RULE3: inputs one to five share filter time
// RULE4: inputs six to nine have second filter time
// RULE5: level change accepted only after stable interval
// RULE6: polarity word, one bit per input
// RULE7: positive active when connected, negative when open
// RULE8: five output selectors, codes 0 to 71
// RULE9: codes 1, 2 follow ready and running
// RULE10: code 3 means no fault and bus normal
// RULE11: codes 4, 5, 6 follow fault, alarm, either
// RULE12: codes 7, 8 follow reverse and run command
// RULE13: code 9 running, zero frequency, current present; code takes run command, not running
// RULE14: code 10 speed or frequency nonzero by mode
// RULE15: codes 11, 12, 14 undervoltage, remote, regeneration
// RULE16: codes 19, 20, 22 give half second pulse
// RULE17: code 21 holds level after full cycle
// RULE18: code 23 wobble beyond frequency limits
// RULE19: code 24 follows encoder direction
// RULE20: codes 26/29/32 set below low, clear above
// RULE21: codes 27/30/33 set above high, clear below
// RULE22: codes 28/31/34 active inside limits inclusive
// RULE23: each output delays turn on and off
// RULE24: reset clears filters, timers, latches and outputs
`timescale 1ns/1ps
`include "mt_map.svh"
module mt_terminal_io #(
	parameter int MS_CYCLES = `MT_CLK_HZ / 1000 * `MT_TICK_MS // 1 ms tick
) (
	input  wire logic           I_CORE_CLK,     // core clock 125 MHz
	input  wire logic           I_RST_N,        // async reset, active low
	input  wire logic           I_WB_CYC,       // wishbone cycle
	input  wire logic           I_WB_STB,       // wishbone strobe
	input  wire logic           I_WB_WE,        // wishbone write enable
	input  wire logic [7:0]     I_WB_ADR,       // wishbone byte address
	input  wire logic [31:0]    I_WB_DAT,       // wishbone write data
	input  wire logic [3:0]     I_WB_SEL,       // wishbone byte lanes
	output logic [31:0]         O_WB_DAT,       // wishbone read data
	output logic                O_WB_ACK,       // wishbone acknowledge
	input  wire logic [8:0]     I_DIN,          // raw inputs, 1 = closed
	input  wire logic           I_READY,        // drive ready to run
	input  wire logic           I_RUNNING,      // drive running
	input  wire logic           I_FAULT,        // fault flag
	input  wire logic           I_ALARM,        // alarm flag
	input  wire logic           I_BUS_OK,       // dc bus voltage normal
	input  wire logic           I_REVERSE,      // motor turns in reverse
	input  wire logic           I_RUN_CMD,      // run command asserted
	input  wire logic           I_FREQ_ZERO,    // output frequency zero
	input  wire logic           I_CURRENT_ON,   // output current present
	input  wire logic           I_SPEED_ZERO,   // rotor speed zero
	input  wire logic           I_VECTOR_MODE,  // closed loop vector mode
	input  wire logic           I_UNDERVOLT,    // undervoltage stop
	input  wire logic           I_REMOTE_CMD,   // commands not from panel
	input  wire logic           I_REGEN,        // regenerative braking
	input  wire logic           I_STAGE_DONE,   // stage done, one pulse
	input  wire logic           I_CYCLE_DONE,   // cycle done, one pulse
	input  wire logic           I_WOBBLE_EN,    // wobble enabled
	input  wire logic           I_WOBBLE_HI,    // wobble above upper limit
	input  wire logic           I_WOBBLE_LO,    // wobble below lower limit
	input  wire logic           I_ENC_DIR,      // divided encoder direction
	input  wire mt_pkg::mt_mon_type I_MON_VAL,  // three monitored values
	output logic [2:0]          O_DOUT,         // digital outputs
	output logic [1:0]          O_RELAY,        // relay drives
	output logic [8:0]          O_DIN_ACT,      // filtered active inputs
	output logic [13:0]         O_PULSE_FREQ    // pulse freq, 0.1 kHz
);
	import mt_pkg::*;

	localparam logic [8:0] PULSE_TICKS = 9'(`MT_PULSE_MS / `MT_TICK_MS);
	localparam logic [3:0] DLY_TICKS = 4'(`MT_DLY_UNIT_MS / `MT_TICK_MS);
	localparam logic [3:0] GATE_TICKS = 4'(`MT_GATE_MS / `MT_TICK_MS);

	mt_state_type st;      // registered state
	mt_state_type nx;      // next state
	logic [127:0] cond;    // status condition per function code
	logic         ms_tick; // one cycle per millisecond
	logic         t10;     // one cycle per delay unit
	logic         pmode;   // pulse input function selected
	logic         take;    // bus request taken this cycle

	// hit test for a block of word registers
	function automatic logic rhit(input logic [7:0] a,
			input logic [7:0] b, input logic [7:0] n);
		rhit = (a >= b) && (a < 8'(b + (n << 2))) && (a[1:0] == 2'h0);
	endfunction

	// word index inside a block of registers
	function automatic logic [2:0] ridx(input logic [7:0] a,
			input logic [7:0] b);
		ridx = 3'((a - b) >> 2);
	endfunction

	// byte lane merge for the 16-bit registers
	function automatic logic [15:0] wmerge(input logic [15:0] o,
			input logic [31:0] d, input logic [3:0] s);
		wmerge = {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
	endfunction

	assign ms_tick = st.ms_cnt == 17'(MS_CYCLES - 1);
	assign t10 = ms_tick && (st.tk10 == DLY_TICKS - 4'h1);
	assign pmode = (st.pfn == `MT_PULSE_LO) || (st.pfn == `MT_PULSE_HI);
	assign take = (st.bus == MT_IDLE) && I_WB_CYC && I_WB_STB;

	// status conditions indexed by function code; unlisted codes stay low
	always_comb begin
		cond = '0;
		cond[`MT_FN_READY] = I_READY; // RULE9
		cond[`MT_FN_RUN] = I_RUNNING; // RULE9
		cond[`MT_FN_NORMAL] = !I_FAULT && I_BUS_OK; // RULE10
		cond[`MT_FN_FAULT] = I_FAULT; // RULE11
		cond[`MT_FN_ALARM] = I_ALARM; // RULE11
		cond[`MT_FN_FLT_ALM] = I_FAULT || I_ALARM; // RULE11
		cond[`MT_FN_REVERSE] = I_REVERSE; // RULE12
		cond[`MT_FN_RUN_CMD] = I_RUN_CMD; // RULE12
		cond[`MT_FN_ZERO_RUN] = I_RUN_CMD && I_FREQ_ZERO && I_CURRENT_ON; // RULE13
		// vector mode looks at rotor speed, open loop at frequency
		cond[`MT_FN_NONZERO] = I_VECTOR_MODE ? !I_SPEED_ZERO
			: !I_FREQ_ZERO; // RULE14
		cond[`MT_FN_UNDERV] = I_UNDERVOLT; // RULE15
		cond[`MT_FN_REMOTE] = I_REMOTE_CMD; // RULE15
		cond[`MT_FN_REGEN] = I_REGEN; // RULE15
		cond[`MT_FN_STAGE] = st.stg_cnt != 9'h000; // RULE16
		cond[`MT_FN_CYC_P] = st.cyc_cnt != 9'h000; // RULE16
		cond[`MT_FN_CYC_P2] = st.cyc_cnt != 9'h000; // RULE16
		cond[`MT_FN_CYC_L] = st.cyc_lvl; // RULE17
		cond[`MT_FN_WOBBLE] = I_WOBBLE_EN
			&& (I_WOBBLE_HI || I_WOBBLE_LO); // RULE18
		cond[`MT_FN_ENC_DIR] = I_ENC_DIR; // RULE19
		for (int k = 0; k < 3; k++) begin
			cond[`MT_FN_MON_BASE + `MT_FN_MON_STEP * k] = st.mon_low[k]; // RULE20
			cond[`MT_FN_MON_BASE + `MT_FN_MON_STEP * k + 1] = st.mon_high[k]; // RULE21
			// equality with a limit counts as inside
			cond[`MT_FN_MON_BASE + `MT_FN_MON_STEP * k + 2] =
				(I_MON_VAL[k] >= st.mon_lo[k])
				&& (I_MON_VAL[k] <= st.mon_hi[k]); // RULE22
		end
		for (int i = 0; i < 8; i++) begin
			cond[`MT_FN_DIN_BASE + i] = st.din_act[i];
		end
	end

	// next state: bus slave, filters, timers, latches, output delays
	always_comb begin
		logic [31:0] rd;
		logic [5:0]  lim;
		logic [9:0]  dly;
		logic        req;
		logic [15:0] w;
		rd = 32'h0;
		lim = `MT_FILT_MIN;
		dly = 10'h000;
		req = 1'b0;
		w = 16'h0000;
		nx = st;
		// read mux; unmapped addresses read zero
		if (I_WB_ADR == `MT_REG_FILT_A) begin
			rd[5:0] = st.filt_a;
		end else if (I_WB_ADR == `MT_REG_FILT_B) begin
			rd[5:0] = st.filt_b;
		end else if (I_WB_ADR == `MT_REG_POL) begin
			rd[11:0] = st.pol;
		end else if (I_WB_ADR == `MT_REG_PULSE_FN) begin
			rd[6:0] = st.pfn;
		end else if (I_WB_ADR == `MT_REG_STATUS) begin
			rd[8:0] = st.din_act;
			rd[`MT_STAT_OUT +: 5] = st.out;
		end else if (I_WB_ADR == `MT_REG_FREQ) begin
			rd[13:0] = st.freq;
		end else if (rhit(I_WB_ADR, `MT_REG_OUT_FN, `MT_N_OUT)) begin
			rd[6:0] = st.fn[ridx(I_WB_ADR, `MT_REG_OUT_FN)];
		end else if (rhit(I_WB_ADR, `MT_REG_ON_DLY, `MT_N_OUT)) begin
			rd[9:0] = st.on_dly[ridx(I_WB_ADR, `MT_REG_ON_DLY)];
		end else if (rhit(I_WB_ADR, `MT_REG_OFF_DLY, `MT_N_OUT)) begin
			rd[9:0] = st.off_dly[ridx(I_WB_ADR, `MT_REG_OFF_DLY)];
		end else if (rhit(I_WB_ADR, `MT_REG_MON_LO, `MT_N_MON)) begin
			rd[15:0] = st.mon_lo[ridx(I_WB_ADR, `MT_REG_MON_LO)];
		end else if (rhit(I_WB_ADR, `MT_REG_MON_HI, `MT_N_MON)) begin
			rd[15:0] = st.mon_hi[ridx(I_WB_ADR, `MT_REG_MON_HI)];
		end
		// bus handshake: answer one cycle after the request is taken
		case (st.bus)
			MT_IDLE: begin
				if (take) begin
					nx.bus = MT_ACK;
					nx.rdata = I_WB_WE ? st.rdata : rd;
				end
			end
			MT_ACK: begin
				nx.bus = MT_IDLE;
			end
			default: begin
				nx.bus = MT_IDLE;
			end
		endcase
		// writes; out of range values are dropped so settings stay legal
		if (take && I_WB_WE) begin
			if (I_WB_ADR == `MT_REG_FILT_A) begin
				w = wmerge(16'(st.filt_a), I_WB_DAT, I_WB_SEL);
				if (w >= 16'(`MT_FILT_MIN) && w <= 16'(`MT_FILT_MAX)) begin
					nx.filt_a = w[5:0]; // RULE3
				end
			end else if (I_WB_ADR == `MT_REG_FILT_B) begin
				w = wmerge(16'(st.filt_b), I_WB_DAT, I_WB_SEL);
				if (w >= 16'(`MT_FILT_MIN) && w <= 16'(`MT_FILT_MAX)) begin
					nx.filt_b = w[5:0]; // RULE4
				end
			end else if (I_WB_ADR == `MT_REG_POL) begin
				w = wmerge(16'(st.pol), I_WB_DAT, I_WB_SEL);
				nx.pol = w[11:0]; // RULE6
			end else if (I_WB_ADR == `MT_REG_PULSE_FN) begin
				w = wmerge(16'(st.pfn), I_WB_DAT, I_WB_SEL);
				nx.pfn = w[6:0];
			end else if (rhit(I_WB_ADR, `MT_REG_OUT_FN, `MT_N_OUT)) begin
				w = wmerge(16'(st.fn[ridx(I_WB_ADR, `MT_REG_OUT_FN)]),
					I_WB_DAT, I_WB_SEL);
				if (w <= 16'(`MT_FN_MAX)) begin
					nx.fn[ridx(I_WB_ADR, `MT_REG_OUT_FN)] = w[6:0]; // RULE8
				end
			end else if (rhit(I_WB_ADR, `MT_REG_ON_DLY, `MT_N_OUT)) begin
				w = wmerge(16'(st.on_dly[ridx(I_WB_ADR, `MT_REG_ON_DLY)]),
					I_WB_DAT, I_WB_SEL);
				if (w <= 16'(`MT_DLY_MAX)) begin
					nx.on_dly[ridx(I_WB_ADR, `MT_REG_ON_DLY)] = w[9:0];
				end
			end else if (rhit(I_WB_ADR, `MT_REG_OFF_DLY, `MT_N_OUT)) begin
				w = wmerge(16'(st.off_dly[ridx(I_WB_ADR, `MT_REG_OFF_DLY)]),
					I_WB_DAT, I_WB_SEL);
				if (w <= 16'(`MT_DLY_MAX)) begin
					nx.off_dly[ridx(I_WB_ADR, `MT_REG_OFF_DLY)] = w[9:0];
				end
			end else if (rhit(I_WB_ADR, `MT_REG_MON_LO, `MT_N_MON)) begin
				nx.mon_lo[ridx(I_WB_ADR, `MT_REG_MON_LO)] = wmerge(
					st.mon_lo[ridx(I_WB_ADR, `MT_REG_MON_LO)], I_WB_DAT,
					I_WB_SEL);
			end else if (rhit(I_WB_ADR, `MT_REG_MON_HI, `MT_N_MON)) begin
				nx.mon_hi[ridx(I_WB_ADR, `MT_REG_MON_HI)] = wmerge(
					st.mon_hi[ridx(I_WB_ADR, `MT_REG_MON_HI)], I_WB_DAT,
					I_WB_SEL);
			end
		end
		// millisecond and delay unit timebase
		nx.ms_cnt = ms_tick ? 17'h00000 : 17'(st.ms_cnt + 17'h00001);
		if (t10) begin
			nx.tk10 = 4'h0;
		end else if (ms_tick) begin
			nx.tk10 = st.tk10 + 4'h1;
		end
		// debounce: any bounce restarts the count, so only stable levels pass
		for (int i = 0; i < 9; i++) begin
			lim = (i < `MT_GRP_A_N) ? st.filt_a : st.filt_b; // RULE3 RULE4
			if (I_DIN[i] == st.din_f[i]) begin
				nx.db_cnt[i] = 6'h00; // RULE5
			end else if (ms_tick) begin
				// one tick past the limit: the level held the whole interval
				if (st.db_cnt[i] + 6'h01 > lim) begin
					nx.din_f[i] = I_DIN[i]; // RULE5
					nx.db_cnt[i] = 6'h00;
				end else begin
					nx.db_cnt[i] = st.db_cnt[i] + 6'h01;
				end
			end
		end
		// a set bit inverts: open contact then counts as active
		nx.din_act = st.din_f ^ st.pol[8:0]; // RULE6 RULE7
		if (pmode) begin
			// the pulse pin carries no level function in pulse mode
			nx.din_f[`MT_DIN_PULSE] = 1'b0;
			nx.din_act[`MT_DIN_PULSE] = 1'b0;
		end
		// pulse frequency: rising edges counted over a 10 ms gate
		nx.pin_d = I_DIN[`MT_DIN_PULSE];
		if (!pmode) begin
			nx.gate = 4'h0;
			nx.edge_cnt = 14'h0000;
			nx.freq = 14'h0000;
		end else begin
			if (I_DIN[`MT_DIN_PULSE] && !st.pin_d
					&& st.edge_cnt != `MT_EDGE_SAT) begin
				nx.edge_cnt = st.edge_cnt + 14'h0001;
			end
			if (ms_tick) begin
				nx.gate = st.gate + 4'h1;
				if (st.gate == GATE_TICKS - 4'h1) begin
					nx.gate = 4'h0;
					// an edge on the restart cycle opens the next window
					nx.edge_cnt = nx.edge_cnt - st.edge_cnt;
					if (st.pfn == `MT_PULSE_LO) begin
						// out of band trains read as zero or clip
						nx.freq = (st.edge_cnt < `MT_FREQ_MIN_LO) ? 14'h0000
							: (st.edge_cnt > `MT_FREQ_MAX_LO) ? `MT_FREQ_MAX_LO
							: st.edge_cnt; // RULE1
					end else begin
						nx.freq = (st.edge_cnt < `MT_FREQ_MIN_HI) ? 14'h0000
							: (st.edge_cnt > `MT_FREQ_MAX_HI) ? `MT_FREQ_MAX_HI
							: st.edge_cnt; // RULE2
					end
				end
			end
		end
		// half second pulses; a new event restarts the pulse
		if (I_STAGE_DONE) begin
			nx.stg_cnt = PULSE_TICKS; // RULE16
		end else if (ms_tick && st.stg_cnt != 9'h000) begin
			nx.stg_cnt = st.stg_cnt - 9'h001;
		end
		if (I_CYCLE_DONE) begin
			nx.cyc_cnt = PULSE_TICKS; // RULE16
		end else if (ms_tick && st.cyc_cnt != 9'h000) begin
			nx.cyc_cnt = st.cyc_cnt - 9'h001;
		end
		// level held until the run command drops; a new cycle wins
		if (I_CYCLE_DONE) begin
			nx.cyc_lvl = 1'b1; // RULE17
		end else if (!I_RUN_CMD) begin
			nx.cyc_lvl = 1'b0;
		end
		// hysteresis latches
		for (int k = 0; k < 3; k++) begin
			if (I_MON_VAL[k] < st.mon_lo[k]) begin
				nx.mon_low[k] = 1'b1; // RULE20
				nx.mon_high[k] = 1'b0; // RULE21
			end else if (I_MON_VAL[k] > st.mon_hi[k]) begin
				nx.mon_low[k] = 1'b0; // RULE20
				nx.mon_high[k] = 1'b1; // RULE21
			end
		end
		// output delays in 10 ms units; zero switches next cycle
		for (int k = 0; k < 5; k++) begin
			req = cond[st.fn[k]];
			dly = req ? st.on_dly[k] : st.off_dly[k];
			if (req == st.out[k]) begin
				nx.dly_cnt[k] = 10'h000;
			end else if (st.dly_cnt[k] >= dly) begin
				nx.out[k] = req; // RULE23
				nx.dly_cnt[k] = 10'h000;
			end else if (t10) begin
				nx.dly_cnt[k] = st.dly_cnt[k] + 10'h001; // RULE23
			end
		end
	end

	// state register; reset loads constants only
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			st <= '0; // RULE24
			st.filt_a <= `MT_FILT_RST;
			st.filt_b <= `MT_FILT_RST;
			st.pol <= `MT_POL_RST;
			st.fn <= `MT_FN_RST;
			st.mon_hi <= {3{`MT_MON_HI_RST}};
		end else begin
			st <= nx;
		end
	end

	assign O_WB_ACK = st.bus == MT_ACK;
	assign O_WB_DAT = st.rdata;
	assign O_DOUT = st.out[2:0];
	assign O_RELAY = st.out[4:3];
	assign O_DIN_ACT = st.din_act;
	assign O_PULSE_FREQ = st.freq;

	default clocking cb @(posedge I_CORE_CLK);
	endclocking
	default disable iff (!I_RST_N);

	sequence s_rd_filt;
		take && !I_WB_WE && I_WB_ADR == `MT_REG_FILT_A;
	endsequence
	property p_rd_filt;
		s_rd_filt |=> O_WB_ACK && O_WB_DAT[5:0] == $past(st.filt_a);
	endproperty
	a_read_filt_time: assert property (p_rd_filt) // RULE3
		else $error("filter time read back wrong");
	a_filt_b_range: assert property (st.filt_b >= `MT_FILT_MIN
		&& st.filt_b <= `MT_FILT_MAX) // RULE4
		else $error("group b filter time out of range");
	a_filter_on_tick: assert property (!$stable(st.din_f)
		&& !pmode |-> $past(ms_tick)) // RULE5
		else $error("filtered input moved off tick");
	a_polarity_apply: assert property ($stable(st.din_f) [*2]
		|-> st.din_act[0] == (st.din_f[0] ^ $past(st.pol[0]))) // RULE7
		else $error("polarity not applied");
	a_fn_in_range: assert property (st.fn[0] <= `MT_FN_MAX
		&& st.fn[3] <= `MT_FN_MAX && st.fn[4] <= `MT_FN_MAX) // RULE8
		else $error("function code beyond range");
	a_freq_cap: assert property (st.freq <= `MT_FREQ_MAX_HI) // RULE2
		else $error("pulse frequency beyond range");
	a_freq_idle: assert property (!pmode |=> st.freq == 14'h0000) // RULE1
		else $error("frequency kept outside pulse mode");
	a_stage_pulse: assert property (I_STAGE_DONE
		|=> st.stg_cnt == PULSE_TICKS ##1 cond[`MT_FN_STAGE]) // RULE16
		else $error("stage pulse not started");
	a_cycle_level: assert property (st.cyc_lvl && I_RUN_CMD
		|=> st.cyc_lvl) // RULE17
		else $error("cycle level lost while running");
	a_hyst_low: assert property (st.mon_low[0]
		&& I_MON_VAL[0] <= st.mon_hi[0] |=> st.mon_low[0]) // RULE20
		else $error("low latch released early");
	a_hyst_high: assert property (I_MON_VAL[1] > st.mon_hi[1]
		|=> st.mon_high[1]) // RULE21
		else $error("high latch not set");
	a_out_no_delay: assert property (st.on_dly[0] == 10'h000
		&& st.off_dly[0] == 10'h000 && cond[st.fn[0]] != st.out[0]
		|=> st.out[0] == $past(cond[st.fn[0]])) // RULE23
		else $error("output did not follow without delay");
endmodule

// ==== bench/mt_field_model.sv ====
// field side model: contact switches and a pulse source on the ninth input
`timescale 1ns/1ps
module mt_field_model (
	input  wire logic       i_clk,     // clock for pulse timing
	input  wire logic [8:0] i_contact, // 1 = contact closed to return
	input  wire logic [7:0] i_period,  // pulse period in cycles, 0 = off
	output logic      [8:0] o_din      // levels seen at the terminals
);
	logic [7:0] cnt_r = 8'h00; // position within the pulse period
	// free running period counter, restarts at the programmed length
	always_ff @(posedge i_clk) begin
		if (cnt_r + 8'h01 >= i_period) begin
			cnt_r <= 8'h00;
		end else begin
			cnt_r <= cnt_r + 8'h01;
		end
	end
	// half period high keeps each pulse many cycles wide
	assign o_din = {(i_period == 8'h00) ? i_contact[8] :
		(cnt_r < (i_period >> 1)), i_contact[7:0]};
endmodule

// ==== bench/tb_multifunction_terminal_io.sv ====
// self-checking bench for the multifunction terminal block
`timescale 1ns/1ps
`include "mt_map.svh"
module tb_multifunction_terminal_io;
	import mt_pkg::*;
	localparam int MS = 20; // shortened 1 ms tick keeps the run short
	localparam logic [7:0] RV [8] = '{8'h05, 8'h05, 8'h00, 8'h01,
		8'h02, 8'h3F, 8'h04, 8'h05};
	localparam logic [23:0] RF [8] = '{24'h000005, 24'h003305, 24'h003232,
		24'h000505, 24'h0C4801, 24'h0C4747, 24'h0C0101, 24'h70FF00};
	localparam logic [25:0] TV [28] = '{
		{7'd1, 1'b1, 18'h00001}, {7'd1, 1'b0, 18'h3FFFE},
		{7'd2, 1'b1, 18'h00002}, {7'd3, 1'b1, 18'h00010},
		{7'd3, 1'b0, 18'h00014}, {7'd4, 1'b1, 18'h00004},
		{7'd5, 1'b1, 18'h00008}, {7'd6, 1'b1, 18'h00004},
		{7'd6, 1'b1, 18'h00008}, {7'd6, 1'b0, 18'h3FFF3},
		{7'd7, 1'b1, 18'h00020}, {7'd8, 1'b1, 18'h00040},
		{7'd9, 1'b1, 18'h001C0}, {7'd9, 1'b0, 18'h000C0},
		{7'd10, 1'b1, 18'h00400}, {7'd10, 1'b0, 18'h00600},
		{7'd10, 1'b1, 18'h00200}, {7'd10, 1'b0, 18'h00080},
		{7'd11, 1'b1, 18'h00800}, {7'd12, 1'b1, 18'h01000},
		{7'd14, 1'b1, 18'h02000}, {7'd23, 1'b1, 18'h0C000},
		{7'd23, 1'b1, 18'h14000}, {7'd23, 1'b0, 18'h38000},
		{7'd24, 1'b1, 18'h20000}, {7'd0, 1'b0, 18'h3FFFF},
		{7'd63, 1'b0, 18'h3FFFF}, {7'd55, 1'b1, 18'h00000}};
	localparam logic [18:0] HV [7] = '{{16'd150, 3'b100}, {16'd50, 3'b001},
		{16'd150, 3'b101}, {16'd200, 3'b101}, {16'd250, 3'b010},
		{16'd100, 3'b110}, {16'd99, 3'b001}};
	logic        clk = 1'b0;       // core clock
	logic        rst_n = 1'b0;     // reset, active low
	logic        cyc = 1'b0;       // bus cycle
	logic        stb = 1'b0;       // bus strobe
	logic        we = 1'b0;        // bus direction
	logic [7:0]  adr = 8'h00;      // bus address
	logic [31:0] dat = 32'h0;      // bus write data
	logic [3:0]  sel = 4'h3;       // only the two low lanes matter
	logic [17:0] st = 18'h0;       // drive status levels
	logic [1:0]  ev = 2'b00;       // stage and cycle done events
	logic [8:0]  con = 9'h0;       // switch contacts
	logic [7:0]  per = 8'h00;      // pulse source period
	mt_mon_type  mon = '0;         // monitored values
	logic [31:0] rdat, q;          // read data, last read
	logic        ack;              // bus acknowledge
	logic [2:0]  dout;             // digital outputs
	logic [1:0]  rly;              // relay drives
	logic [8:0]  act, din;         // filtered state, terminal levels
	logic [13:0] freq;             // measured pulse rate
	int          err_total = 0;    // mismatches
	int          checks_done = 0;  // comparisons

	mt_terminal_io #(.MS_CYCLES(MS)) dut (
		.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_WB_CYC(cyc), .I_WB_STB(stb),
		.I_WB_WE(we), .I_WB_ADR(adr), .I_WB_DAT(dat), .I_WB_SEL(sel),
		.O_WB_DAT(rdat), .O_WB_ACK(ack), .I_DIN(din), .I_READY(st[0]),
		.I_RUNNING(st[1]), .I_FAULT(st[2]), .I_ALARM(st[3]),
		.I_BUS_OK(st[4]), .I_REVERSE(st[5]), .I_RUN_CMD(st[6]),
		.I_FREQ_ZERO(st[7]), .I_CURRENT_ON(st[8]), .I_SPEED_ZERO(st[9]),
		.I_VECTOR_MODE(st[10]), .I_UNDERVOLT(st[11]),
		.I_REMOTE_CMD(st[12]), .I_REGEN(st[13]), .I_STAGE_DONE(ev[0]),
		.I_CYCLE_DONE(ev[1]), .I_WOBBLE_EN(st[14]), .I_WOBBLE_HI(st[15]),
		.I_WOBBLE_LO(st[16]), .I_ENC_DIR(st[17]), .I_MON_VAL(mon),
		.O_DOUT(dout), .O_RELAY(rly), .O_DIN_ACT(act), .O_PULSE_FREQ(freq));
	mt_field_model fld (.i_clk(clk), .i_contact(con), .i_period(per),
		.o_din(din));

	// 125 MHz clock
	initial begin
		forever #4 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [31:0] got,
		input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value %s exp %0h got %0h", nm, exp, got);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// classic cycle: hold everything until ack is seen, then release
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		{cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (ack !== 1'b1) err_total++;
		q = rdat;
		{cyc, stb} <= 2'b00;
	endtask
	task automatic t_reset;
		for (int i = 0; i < 8; i++) begin
			wb(1'b0, 8'(4 * i), 32'h0);
			chk("reset value", q, 32'(RV[i]));
		end
	endtask
	// out of range writes are dropped, an unmapped place reads zero
	task automatic t_refuse;
		for (int i = 0; i < 8; i++) begin
			wb(1'b1, RF[i][23:16], 32'(RF[i][15:8]));
			wb(1'b0, RF[i][23:16], 32'h0);
			chk("write guard", q, 32'(RF[i][7:0]));
		end
	endtask
	task automatic t_filter;
		con[0] <= 1'b1;
		repeat (3 * MS) @(posedge clk);
		con[0] <= 1'b0;
		repeat (10) @(posedge clk);
		chk("glitch", act[0], 0);
		con[0] <= 1'b1;
		repeat (6 * MS + 5) @(posedge clk);
		chk("settled", act[0], 1);
		wb(1'b1, `MT_REG_FILT_B, 32'h2);
		con[5] <= 1'b1;
		con[1] <= 1'b1;
		repeat (4 * MS) @(posedge clk);
		chk("group b", act[5:0], 6'h21);
		repeat (4 * MS) @(posedge clk);
		chk("group a", act[5:0], 6'h23);
	endtask
	task automatic t_polarity;
		wb(1'b1, `MT_REG_POL, 32'h5);
		repeat (5) @(posedge clk);
		chk("inverted", act[2:0], 3'b110);
		wb(1'b1, `MT_REG_POL, 32'h0);
		repeat (5) @(posedge clk);
		chk("plain", act[2:0], 3'b011);
		wb(1'b0, `MT_REG_STATUS, 32'h0);
		chk("status", q, 32'h23);
	endtask
	task automatic t_codes;
		for (int i = 0; i < 5; i++) wb(1'b1, 8'(12 + 4 * i), 32'h4);
		st <= 18'h00004;
		repeat (5) @(posedge clk);
		chk("all outputs", {rly, dout}, 5'h1F);
		for (int i = 0; i < 28; i++) begin
			st <= TV[i][17:0];
			wb(1'b1, `MT_REG_OUT_FN, 32'(TV[i][25:19]));
			repeat (5) @(posedge clk);
			chk("route", dout[0], TV[i][18]);
		end
	endtask
	task automatic t_hyst;
		for (int k = 0; k < 3; k++) begin
			mon <= {3{16'd150}};
			wb(1'b1, 8'(`MT_REG_MON_LO + 4 * k), 32'd100);
			wb(1'b1, 8'(`MT_REG_MON_HI + 4 * k), 32'd200);
			for (int j = 0; j < 3; j++) begin
				wb(1'b1, 8'(16 + 4 * j), 32'(26 + 3 * k + j));
			end
			for (int s = 0; s < 7; s++) begin
				mon <= {3{HV[s][18:3]}};
				repeat (5) @(posedge clk);
				chk("monitor", {rly[0], dout[2:1]}, HV[s][2:0]);
			end
		end
	endtask
	// half second pulses and the held cycle level
	task automatic t_events;
		localparam logic [6:0] EC [5] = '{7'd19, 7'd20, 7'd22, 7'd28, 7'd21};
		for (int i = 0; i < 5; i++) wb(1'b1, 8'(12 + 4 * i), 32'(EC[i]));
		st <= 18'h00040;
		ev <= 2'b11;
		@(posedge clk);
		ev <= 2'b00;
		repeat (490 * MS) @(posedge clk);
		chk("event pulse", {rly, dout}, 5'b10111);
		repeat (20 * MS) @(posedge clk);
		chk("pulse end", {rly, dout}, 5'b10000);
		st <= 18'h0;
		repeat (5) @(posedge clk);
		chk("level clear", rly[1], 0);
	endtask
	task automatic t_delay;
		wb(1'b1, `MT_REG_OUT_FN, 32'h4);
		wb(1'b1, `MT_REG_ON_DLY, 32'h3);
		wb(1'b1, `MT_REG_OFF_DLY, 32'h2);
		st <= 18'h00004;
		repeat (15 * MS) @(posedge clk);
		chk("on wait", dout[0], 0);
		repeat (20 * MS) @(posedge clk);
		chk("on done", dout[0], 1);
		st <= 18'h0;
		repeat (7 * MS) @(posedge clk);
		chk("off wait", dout[0], 1);
		repeat (15 * MS) @(posedge clk);
		chk("off done", dout[0], 0);
	endtask
	// 25 cycle period gives 8 edges per 10 ms gate, 10 cycles gives 20
	task automatic t_pulse;
		per <= 8'd25;
		wb(1'b1, `MT_REG_PULSE_FN, 32'd97);
		repeat (30 * MS) @(posedge clk);
		chk("rate low", freq, 8);
		chk("pin level", act[8], 0);
		wb(1'b1, `MT_REG_PULSE_FN, 32'd98);
		repeat (30 * MS) @(posedge clk);
		chk("below range", freq, 0);
		per <= 8'd10;
		repeat (30 * MS) @(posedge clk);
		chk("rate high", freq, 20);
	endtask
	// main sequence
	initial begin
		repeat (2) @(posedge clk);
		chk("reset outs", {rly, dout, act, freq}, 0);
		rst_n <= 1'b1;
		t_reset;
		t_refuse;
		t_filter;
		t_polarity;
		t_codes;
		t_hyst;
		t_events;
		t_delay;
		t_pulse;
		wrap_up;
	end
	// cut a hang short well past the expected run length
	initial begin
		repeat (60000) @(posedge clk);
		err_total++;
		wrap_up;
	end
endmodule
